// *** hdl/pfs_pkg.sv ***
`default_nettype none
package pfs_pkg;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned PROG_DEPTH = 32;
	localparam int unsigned ENT_W      = 18;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FMT  = 8'h04;
	localparam logic [7:0] OFS_FCFG = 8'h08;
	localparam logic [7:0] OFS_FVAL = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_BDIV = 8'h14;
	localparam logic [7:0] OFS_PLEN = 8'h18;
	localparam logic [7:0] OFS_PROG = 8'h80;

	localparam int unsigned CTRL_RUN_BIT    = 0;
	localparam int unsigned FMT_WIDTH_LSB   = 0;
	localparam int unsigned FMT_FLEN_LSB    = 16;
	localparam int unsigned FCFG_DOWN_BIT   = 0;
	localparam int unsigned FCFG_MINONE_BIT = 1;
	localparam int unsigned FCFG_MAX_LSB    = 16;
	localparam int unsigned STAT_RUN_BIT    = 0;
	localparam int unsigned STAT_REF_BIT    = 1;
	localparam int unsigned STAT_WIDX_LSB   = 16;
	localparam int unsigned ENT_TYPE_LSB    = 16;

	localparam logic [4:0]  WIDTH_MIN = 5'h04;
	localparam logic [4:0]  WIDTH_MAX = 5'h10;
	localparam logic [12:0] FLEN_MIN  = 13'h0008;
	localparam logic [12:0] FLEN_MAX  = 13'h1000;
	localparam logic [5:0]  PLEN_MIN  = 6'h01;
	localparam logic [5:0]  PLEN_MAX  = 6'h20;
	localparam logic [15:0] CMAX_MIN  = 16'h0001;

	localparam logic [4:0]  RST_WIDTH = 5'h08;
	localparam logic [12:0] RST_FLEN  = 13'h0008;
	localparam logic [15:0] RST_CMAX  = 16'hffff;
	localparam logic [5:0]  RST_PLEN  = 6'h01;
	localparam logic [15:0] RST_BDIV  = 16'h0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_SYNC = 2'h0,
		OP_IMM  = 2'h1,
		OP_FCNT = 2'h2,
		OP_REP  = 2'h3
	} pfs_op_t;
endpackage
`default_nettype wire

// *** hdl/pfs_word_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface pfs_word_if;
	logic        valid;
	logic        ready;
	logic        sof;
	logic [15:0] data;
	logic [4:0]  width;
	logic        run;
	logic [15:0] bit_div;

	modport seq (output valid, sof, data, width, run, bit_div, input ready);
	modport ser (input valid, sof, data, width, run, bit_div, output ready);
endinterface
`default_nettype wire

// *** hdl/pfs_serializer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_serializer (
	input  wire logic  aclk,           // System clock
	input  wire logic  aresetn,        // Synchronous reset, low
	pfs_word_if.ser    w,              // Words from the sequencer
	output var logic   pcm_data,       // Serial PCM bit
	output var logic   pcm_bit_strobe, // Pulse: new bit presented
	output var logic   pcm_frame_sync, // High during first bit of frame
	output var logic   pcm_active      // Stream is being generated
);
	logic [15:0] sh_q, sh_d;
	logic [4:0]  left_q, left_d;
	logic [15:0] div_q, div_d;
	logic        dat_q, dat_d, stb_q, stb_d, sync_q, sync_d, act_q, act_d;
	logic        tick;

	assign tick    = (div_q == 16'h0000);
	// Ready in the last cycle of the last bit keeps words gapless
	assign w.ready = w.run && ((left_q == 5'h00) || (tick && left_q == 5'h01));

	always_comb
	begin
		sh_d   = sh_q;
		left_d = left_q;
		div_d  = div_q;
		dat_d  = dat_q;
		stb_d  = 1'b0;
		sync_d = sync_q;
		act_d  = act_q;
		if (!w.run)
		begin
			left_d = 5'h00;
			div_d  = 16'h0000;
			dat_d  = 1'b0;
			sync_d = 1'b0;
			act_d  = 1'b0; // [R12]
		end
		else if (w.valid && w.ready)
		begin
			sh_d   = w.data;
			left_d = w.width;
			div_d  = w.bit_div;
			dat_d  = w.data[4'(w.width - 5'h01)]; // [R09]
			stb_d  = 1'b1;
			sync_d = w.sof;
			act_d  = 1'b1;
		end
		else if (left_q != 5'h00)
		begin
			if (!tick)
				div_d = div_q - 16'h0001;
			else if (left_q == 5'h01)
			begin
				left_d = 5'h00;
				act_d  = 1'b0;
				sync_d = 1'b0;
			end
			else
			begin
				left_d = left_q - 5'h01;
				div_d  = w.bit_div;
				dat_d  = sh_q[4'(left_q - 5'h02)];
				stb_d  = 1'b1;
				sync_d = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sh_q   <= 16'h0000;
			left_q <= 5'h00;
			div_q  <= 16'h0000;
			dat_q  <= 1'b0;
			stb_q  <= 1'b0;
			sync_q <= 1'b0;
			act_q  <= 1'b0;
		end
		else
		begin
			sh_q   <= sh_d;
			left_q <= left_d;
			div_q  <= div_d;
			dat_q  <= dat_d;
			stb_q  <= stb_d;
			sync_q <= sync_d;
			act_q  <= act_d;
		end
	end

	assign pcm_data       = dat_q;
	assign pcm_bit_strobe = stb_q;
	assign pcm_frame_sync = sync_q;
	assign pcm_active     = act_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_halt;
		!w.run;
	endsequence
	sequence s_quiet;
		!pcm_active && !pcm_bit_strobe;
	endsequence

	a_halt_silent: // [R12]
	assert property (s_halt |=> s_quiet)
		else $error("stream active after halt");
	a_bits_in_range: // [R09]
	assert property (left_q <= pfs_pkg::WIDTH_MAX)
		else $error("bit count above word width limit");
endmodule
`default_nettype wire

// *** hdl/pfs_frame_sequencer.sv ***
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01: Frames of up to 4096 program-made words
// R02: Program store holds 32 type/data entries
// R03: Sync instruction emits its sync-pattern word
// R04: Immediate instruction emits its data field
// R05: Frame-count instruction emits current frame counter
// R06: Repeat re-runs preceding instruction N more times
// R07: Words beyond frame length are discarded
// R08: Program editable only while halted
// R09: Word width configurable 4 to 16 bits
// R10: Frame length configurable 8 to 4096 words
// R11: Frame counter steps per frame, up/down, limits
// R12: Output only in run; halt stops stream
// R13: Program restarts at location 1 each frame
// R14: Counter wraps to opposite limit at end
module pfs_frame_sequencer (
	input  wire logic        aclk,           // System clock, 40 MHz
	input  wire logic        aresetn,        // Synchronous reset, low
	input  wire logic [7:0]  s_axi_awaddr,   // Write address
	input  wire logic [2:0]  s_axi_awprot,   // Unused
	input  wire logic        s_axi_awvalid,  // Write address valid
	output var logic         s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
	input  wire logic        s_axi_wvalid,   // Write data valid
	output var logic         s_axi_wready,   // Write data ready
	output var logic [1:0]   s_axi_bresp,    // Write response
	output var logic         s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [7:0]  s_axi_araddr,   // Read address
	input  wire logic [2:0]  s_axi_arprot,   // Unused
	input  wire logic        s_axi_arvalid,  // Read address valid
	output var logic         s_axi_arready,  // Read address ready
	output var logic [31:0]  s_axi_rdata,    // Read data
	output var logic [1:0]   s_axi_rresp,    // Read response
	output var logic         s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	output var logic         pcm_data,       // Serial PCM bit
	output var logic         pcm_bit_strobe, // Pulse: new bit presented
	output var logic         pcm_frame_sync, // First bit of a frame
	output var logic         pcm_active      // Stream being generated
);
	logic [17:0] prog_mem [pfs_pkg::PROG_DEPTH];
	logic        prog_we;
	logic [4:0]  prog_idx;
	logic [17:0] prog_wdata;

	logic        awr_q, awr_d, wr_q, wr_d, awh_q, awh_d, wh_q, wh_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]  ws_q, ws_d;
	logic        bv_q, bv_d, rv_q, rv_d, arr_q, arr_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic        run_q, run_d, down_q, down_d, min1_q, min1_d, ref_q, ref_d;
	logic [4:0]  width_q, width_d;
	logic [12:0] flen_q, flen_d;
	logic [15:0] cmax_q, cmax_d, bdiv_q, bdiv_d;
	logic [5:0]  plen_q, plen_d;
	logic        wr_fire, wr_locked;
	logic [31:0] wv;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic is_prog(input logic [7:0] a);
		return a[7] == pfs_pkg::OFS_PROG[7];
	endfunction

	function automatic logic is_cfg(input logic [7:0] a);
		return {a[7:2], 2'h0} inside {pfs_pkg::OFS_CTRL, pfs_pkg::OFS_FMT, pfs_pkg::OFS_FCFG,
			pfs_pkg::OFS_FVAL, pfs_pkg::OFS_STAT, pfs_pkg::OFS_BDIV, pfs_pkg::OFS_PLEN};
	endfunction

	// Sequencer state
	logic [5:0]  pc_q, pc_d;
	logic [11:0] widx_q, widx_d;
	logic [15:0] rep_q, rep_d, last_q, last_d, fcnt_q, fcnt_d, od_q, od_d;
	logic        ov_q, ov_d, osof_q, osof_d;
	logic        take, have, frame_end;
	logic [15:0] word, cmin, wmask;
	logic [17:0] ent;

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (is_prog(a))
			r[17:0] = prog_mem[a[6:2]];
		else
			unique case ({a[7:2], 2'h0})
				pfs_pkg::OFS_CTRL: r[pfs_pkg::CTRL_RUN_BIT] = run_q;
				pfs_pkg::OFS_FMT:
				begin
					r[pfs_pkg::FMT_WIDTH_LSB +: 5] = width_q;
					r[pfs_pkg::FMT_FLEN_LSB +: 13] = flen_q;
				end
				pfs_pkg::OFS_FCFG:
				begin
					r[pfs_pkg::FCFG_DOWN_BIT]     = down_q;
					r[pfs_pkg::FCFG_MINONE_BIT]   = min1_q;
					r[pfs_pkg::FCFG_MAX_LSB +: 16] = cmax_q;
				end
				pfs_pkg::OFS_FVAL: r[15:0] = fcnt_q;
				pfs_pkg::OFS_STAT:
				begin
					r[pfs_pkg::STAT_RUN_BIT]       = run_q;
					r[pfs_pkg::STAT_REF_BIT]       = ref_q;
					r[pfs_pkg::STAT_WIDX_LSB +: 12] = widx_q;
				end
				pfs_pkg::OFS_BDIV: r[15:0] = bdiv_q;
				pfs_pkg::OFS_PLEN: r[5:0] = plen_q;
				default: r = 32'h0000_0000;
			endcase
		return r;
	endfunction

	// Register bus and configuration
	always_comb
	begin
		awh_d = awh_q; awa_d = awa_q; wh_d = wh_q; wd_d = wd_q; ws_d = ws_q;
		bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
		run_d = run_q; down_d = down_q; min1_d = min1_q; width_d = width_q;
		flen_d = flen_q; cmax_d = cmax_q; bdiv_d = bdiv_q; plen_d = plen_q;
		ref_d = ref_q;
		prog_we = 1'b0;
		prog_idx = awa_q[6:2];
		wv = 32'h0000_0000;
		if (s_axi_awvalid && awr_q)
		begin
			awh_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_q)
		begin
			wh_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bv_d = 1'b0;
		wr_fire = awh_q && wh_q && !bv_q;
		// Only run control and status stay writable while running
		wr_locked = run_q && ({awa_q[7:2], 2'h0} != pfs_pkg::OFS_CTRL)
			&& ({awa_q[7:2], 2'h0} != pfs_pkg::OFS_STAT); // [R08]
		if (wr_fire)
		begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = (is_prog(awa_q) || is_cfg(awa_q)) ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
			wv    = merge(rd_word(awa_q), wd_q, ws_q);
			if (wr_locked && (is_prog(awa_q) || is_cfg(awa_q)))
				ref_d = 1'b1; // [R08]
			else if (is_prog(awa_q))
				prog_we = 1'b1; // [R02]
			else
				unique case ({awa_q[7:2], 2'h0})
					pfs_pkg::OFS_CTRL: run_d = wv[pfs_pkg::CTRL_RUN_BIT];
					pfs_pkg::OFS_FMT:
					begin
						width_d = wv[pfs_pkg::FMT_WIDTH_LSB +: 5];
						if (width_d < pfs_pkg::WIDTH_MIN)
							width_d = pfs_pkg::WIDTH_MIN; // [R09]
						if (width_d > pfs_pkg::WIDTH_MAX)
							width_d = pfs_pkg::WIDTH_MAX; // [R09]
						flen_d = wv[pfs_pkg::FMT_FLEN_LSB +: 13];
						if (flen_d < pfs_pkg::FLEN_MIN)
							flen_d = pfs_pkg::FLEN_MIN; // [R10]
						if (flen_d > pfs_pkg::FLEN_MAX)
							flen_d = pfs_pkg::FLEN_MAX; // [R01] [R10]
					end
					pfs_pkg::OFS_FCFG:
					begin
						down_d = wv[pfs_pkg::FCFG_DOWN_BIT];
						min1_d = wv[pfs_pkg::FCFG_MINONE_BIT];
						cmax_d = wv[pfs_pkg::FCFG_MAX_LSB +: 16];
						if (cmax_d < pfs_pkg::CMAX_MIN)
							cmax_d = pfs_pkg::CMAX_MIN; // [R11]
					end
					pfs_pkg::OFS_STAT:
						if (wv[pfs_pkg::STAT_REF_BIT])
							ref_d = 1'b0;
					pfs_pkg::OFS_BDIV: bdiv_d = wv[15:0];
					pfs_pkg::OFS_PLEN:
					begin
						plen_d = wv[5:0];
						if (plen_d < pfs_pkg::PLEN_MIN)
							plen_d = pfs_pkg::PLEN_MIN;
						if (plen_d > pfs_pkg::PLEN_MAX)
							plen_d = pfs_pkg::PLEN_MAX; // [R02]
					end
					default: ;
				endcase
		end
		prog_wdata = wv[17:0];
		awr_d = !awh_d;
		wr_d  = !wh_d;
		if (s_axi_rvalid && s_axi_rready)
			rv_d = 1'b0;
		if (s_axi_arvalid && arr_q)
		begin
			rv_d = 1'b1;
			rd_d = rd_word(s_axi_araddr);
			rr_d = (is_prog(s_axi_araddr) || is_cfg(s_axi_araddr)) ?
				pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
		end
		arr_d = !rv_d;
	end

	always_ff @(posedge aclk)
	begin
		if (prog_we)
			prog_mem[prog_idx] <= prog_wdata;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awr_q <= 1'b0; wr_q <= 1'b0; awh_q <= 1'b0; wh_q <= 1'b0;
			awa_q <= 8'h00; wd_q <= 32'h0000_0000; ws_q <= 4'h0;
			bv_q <= 1'b0; br_q <= pfs_pkg::RESP_OKAY; rv_q <= 1'b0; arr_q <= 1'b0;
			rd_q <= 32'h0000_0000; rr_q <= pfs_pkg::RESP_OKAY;
			run_q <= 1'b0; down_q <= 1'b0; min1_q <= 1'b0; ref_q <= 1'b0;
			width_q <= pfs_pkg::RST_WIDTH; flen_q <= pfs_pkg::RST_FLEN;
			cmax_q <= pfs_pkg::RST_CMAX; bdiv_q <= pfs_pkg::RST_BDIV; plen_q <= pfs_pkg::RST_PLEN;
		end
		else
		begin
			awr_q <= awr_d; wr_q <= wr_d; awh_q <= awh_d; wh_q <= wh_d;
			awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
			bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; arr_q <= arr_d;
			rd_q <= rd_d; rr_q <= rr_d;
			run_q <= run_d; down_q <= down_d; min1_q <= min1_d; ref_q <= ref_d;
			width_q <= width_d; flen_q <= flen_d;
			cmax_q <= cmax_d; bdiv_q <= bdiv_d; plen_q <= plen_d;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;

	// Word sequencer
	pfs_word_if wif ();
	assign wif.valid   = ov_q;
	assign wif.sof     = osof_q;
	assign wif.data    = od_q;
	assign wif.width   = width_q;
	assign wif.run     = run_q;
	assign wif.bit_div = bdiv_q;
	assign take        = ov_q && wif.ready;
	assign cmin        = {15'h0000, min1_q};
	assign wmask       = 16'((17'h00001 << width_q) - 17'h00001);

	always_comb
	begin
		pc_d = pc_q; widx_d = widx_q; rep_d = rep_q; last_d = last_q; fcnt_d = fcnt_q;
		ov_d = ov_q; od_d = od_q; osof_d = osof_q;
		have = 1'b0;
		word = 16'h0000;
		frame_end = 1'b0;
		ent = prog_mem[pc_q[4:0]];
		if (!run_q)
		begin
			// Halted: park at frame start so the first frame after run is whole
			pc_d = 6'h00; widx_d = 12'h000; rep_d = 16'h0000; ov_d = 1'b0; // [R12]
			fcnt_d = down_q ? cmax_q : cmin;
		end
		else if (!ov_q || take)
		begin
			ov_d = 1'b0;
			if (rep_q != 16'h0000)
			begin
				have  = 1'b1;
				word  = last_q;
				rep_d = rep_q - 16'h0001; // [R06]
			end
			else if (pc_q < plen_q)
			begin
				pc_d = pc_q + 6'h01; // [R13]
				unique case (pfs_pkg::pfs_op_t'(ent[pfs_pkg::ENT_TYPE_LSB +: 2]))
					pfs_pkg::OP_SYNC, pfs_pkg::OP_IMM:
					begin
						have = 1'b1;
						word = ent[15:0]; // [R03] [R04]
					end
					pfs_pkg::OP_FCNT:
					begin
						have = 1'b1;
						word = fcnt_q; // [R05]
					end
					pfs_pkg::OP_REP:
						// A repeat with nothing before it emits nothing
						if (pc_q != 6'h00 && ent[15:0] != 16'h0000)
						begin
							have  = 1'b1;
							word  = last_q;
							rep_d = ent[15:0] - 16'h0001; // [R06]
						end
				endcase
				if (have)
					last_d = word;
			end
			else
				have = 1'b1;
			if (have)
			begin
				ov_d   = 1'b1;
				od_d   = word & wmask; // [R09]
				osof_d = (widx_q == 12'h000);
				if ({1'b0, widx_q} == flen_q - 13'h0001)
				begin
					// Whatever the program still holds is dropped here
					frame_end = 1'b1;
					widx_d = 12'h000; pc_d = 6'h00; rep_d = 16'h0000; // [R07] [R13]
					if (!down_q)
						fcnt_d = (fcnt_q >= cmax_q) ? cmin : fcnt_q + 16'h0001; // [R11] [R14]
					else
						fcnt_d = (fcnt_q <= cmin) ? cmax_q : fcnt_q - 16'h0001; // [R11] [R14]
				end
				else
					widx_d = widx_q + 12'h001; // [R01]
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pc_q <= 6'h00; widx_q <= 12'h000; rep_q <= 16'h0000; last_q <= 16'h0000;
			fcnt_q <= 16'h0000; ov_q <= 1'b0; od_q <= 16'h0000; osof_q <= 1'b0;
		end
		else
		begin
			pc_q <= pc_d; widx_q <= widx_d; rep_q <= rep_d; last_q <= last_d;
			fcnt_q <= fcnt_d; ov_q <= ov_d; od_q <= od_d; osof_q <= osof_d;
		end
	end

	pfs_serializer u_ser (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.w              (wif.ser),
		.pcm_data       (pcm_data),
		.pcm_bit_strobe (pcm_bit_strobe),
		.pcm_frame_sync (pcm_frame_sync),
		.pcm_active     (pcm_active)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_edit_refused: // [R08]
	assert property (wr_fire && run_q && is_prog(awa_q) |-> !prog_we ##1 ref_q)
		else $error("program edited while running");
	a_width_range: // [R09]
	assert property (width_q >= pfs_pkg::WIDTH_MIN && width_q <= pfs_pkg::WIDTH_MAX)
		else $error("word width out of range");
	a_flen_range: // [R10]
	assert property (flen_q >= pfs_pkg::FLEN_MIN && flen_q <= pfs_pkg::FLEN_MAX)
		else $error("frame length out of range");
	a_widx_bound: // [R07]
	assert property ({1'b0, widx_q} < flen_q)
		else $error("word index beyond frame length");
	a_frame_restart: // [R13]
	assert property (frame_end |=> pc_q == 6'h00 && widx_q == 12'h000 && rep_q == 16'h0000)
		else $error("frame did not restart at first location");
	a_count_step: // [R11]
	assert property (frame_end && !down_q && fcnt_q < cmax_q |=> fcnt_q == $past(fcnt_q) + 16'h0001)
		else $error("frame counter did not step up");
	a_count_wrap: // [R14]
	assert property (frame_end && down_q && fcnt_q <= cmin |=> fcnt_q == $past(cmax_q))
		else $error("frame counter did not wrap down");
	a_repeat_word: // [R06]
	assert property (run_q && (!ov_q || take) && rep_q != 16'h0000 ##1 run_q |-> od_q == ($past(last_q) & wmask))
		else $error("repeat did not emit preceding word");
	a_halt_clear: // [R12]
	assert property (!run_q |=> !ov_q ##1 !pcm_active)
		else $error("words offered while halted");
endmodule
`default_nettype wire

// *** test/pfs_pcm_rx.sv ***
`timescale 1ns/100ps
`default_nettype none
module pfs_pcm_rx (
	input  wire logic       aclk,           // System clock
	input  wire logic       aresetn,        // Synchronous reset, low
	input  wire logic       pcm_data,       // Serial bit from the sequencer
	input  wire logic       pcm_bit_strobe, // New bit presented
	input  wire logic       pcm_frame_sync, // First bit of a frame
	input  wire logic [4:0] width           // Bits per word as configured
);
	logic [15:0] sh;
	int          nb;
	logic        first;
	logic [15:0] words[$];
	logic        sofs[$];

	// Only whole words are kept; a word cut short by a halt is dropped
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nb = 0;
			first = 1'b0;
		end
		else if (pcm_bit_strobe)
		begin
			if (pcm_frame_sync)
			begin
				nb = 0;
				first = 1'b1;
			end
			sh = {sh[14:0], pcm_data};
			nb++;
			if (nb == int'(width))
			begin
				words.push_back(sh & ((16'h1 << width) - 16'h1));
				sofs.push_back(first);
				first = 1'b0;
				nb = 0;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/tb_pcm_tdm_frame_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_pcm_tdm_frame_sequencer;
	logic        aclk, aresetn;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        pcm_data, pcm_bit_strobe, pcm_frame_sync, pcm_active;
	logic [4:0]  width;
	logic [15:0] immediate_word, bdiv, cmax, cmin;
	logic        down, min1;
	int          mismatches, compares, n;

	pfs_frame_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pcm_data,
		.pcm_bit_strobe, .pcm_frame_sync, .pcm_active);
	pfs_pcm_rx rx (.aclk, .aresetn, .pcm_data, .pcm_bit_strobe, .pcm_frame_sync, .width);

	initial
	begin
		aclk = 1'b0;
		forever
			#12.5 aclk = ~aclk;
	end

	task automatic fail(input string msg);
		mismatches++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
			fail($sformatf("register got %h expected %h", g, e));
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		compares++;
		if (g !== e)
			fail($sformatf("response got %h expected %h", g, e));
	endtask

	task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
			fail($sformatf("pcm word got %h expected %h", g, e));
	endtask

	task automatic chk_bit(input logic g, input logic e);
		compares++;
		if (g !== e)
			fail($sformatf("flag got %b expected %b", g, e));
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				chk_resp(s_axi_bresp, er);
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
			begin
				chk_resp(s_axi_rresp, er);
				chk_reg(s_axi_rdata & m, e);
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	// Word k of frame f: sync, sync, counter, immediate, then six repeats cut at eight words
	function automatic logic [15:0] exp_word(input int f, input int k);
		logic [15:0] seq[$];
		logic [15:0] span;
		span = cmax - cmin + 16'h1;
		seq = '{16'h000f, 16'h0003, down ? cmax - 16'(f % span) : cmin + 16'(f % span), immediate_word};
		repeat (6)
			seq.push_back(immediate_word);
		return seq[k] & ((16'h1 << width) - 16'h1);
	endfunction

	task conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#750000;
		fail("timeout");
		conclude();
	end

	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'hf;
		width = 5'h08;
		void'($urandom(32'h3f9f));
		repeat (20)
			@(posedge aclk);
		aresetn <= 1'b1;
		rd(pfs_pkg::OFS_FMT, 32'h0008_0008, 32'hffff_ffff, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_FCFG, 32'hffff_0000, 32'hffff_ffff, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_CTRL, 32'h0, 32'hffff_ffff, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_PLEN, 32'h1, 32'hffff_ffff, pfs_pkg::RESP_OKAY);
		rd(8'h40, 32'h0, 32'h0, pfs_pkg::RESP_SLVERR);
		wr(8'h44, 32'h0, pfs_pkg::RESP_SLVERR);
		width <= 5'(4 + $urandom % 13);
		immediate_word <= 16'($urandom);
		bdiv <= 16'($urandom % 3);
		down <= 1'($urandom);
		min1 <= 1'($urandom);
		cmax <= 16'h0003;
		@(posedge aclk);
		cmin = {15'h0, min1};
		// Everything below up to the run write is edited while halted
		wr(pfs_pkg::OFS_FMT, {16'h0008, 11'h0, width}, pfs_pkg::RESP_OKAY);
		wr(pfs_pkg::OFS_FCFG, {cmax, 14'h0, min1, down}, pfs_pkg::RESP_OKAY);
		wr(pfs_pkg::OFS_BDIV, {16'h0, bdiv}, pfs_pkg::RESP_OKAY);
		wr(pfs_pkg::OFS_PLEN, 32'h5, pfs_pkg::RESP_OKAY);
		wr(8'h80, {14'h0, pfs_pkg::OP_SYNC, 16'h000f}, pfs_pkg::RESP_OKAY);
		wr(8'h84, {14'h0, pfs_pkg::OP_SYNC, 16'h0003}, pfs_pkg::RESP_OKAY);
		wr(8'h88, {14'h0, pfs_pkg::OP_FCNT, 16'h0000}, pfs_pkg::RESP_OKAY);
		wr(8'h8c, {14'h0, pfs_pkg::OP_IMM, immediate_word}, pfs_pkg::RESP_OKAY);
		wr(8'h90, {14'h0, pfs_pkg::OP_REP, 16'h0006}, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_FVAL, {16'h0, down ? cmax : cmin}, 32'hffff, pfs_pkg::RESP_OKAY);
		chk_reg(32'(rx.words.size()), 32'h0);
		wr(pfs_pkg::OFS_CTRL, 32'h1, pfs_pkg::RESP_OKAY);
		wr(pfs_pkg::OFS_PLEN, 32'h3, pfs_pkg::RESP_OKAY);
		wr(8'h8c, {14'h0, pfs_pkg::OP_IMM, ~immediate_word}, pfs_pkg::RESP_OKAY);
		rd(8'h8c, {14'h0, pfs_pkg::OP_IMM, immediate_word}, 32'h3_ffff, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_PLEN, 32'h5, 32'h3f, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_STAT, 32'h3, 32'h3, pfs_pkg::RESP_OKAY);
		wr(pfs_pkg::OFS_STAT, 32'h2, pfs_pkg::RESP_OKAY);
		rd(pfs_pkg::OFS_STAT, 32'h1, 32'h3, pfs_pkg::RESP_OKAY);
		for (n = 0; n < 8000 && rx.words.size() < 32; n++)
			@(posedge aclk);
		chk_reg(32'(rx.words.size() >= 32), 32'h1);
		for (int f = 0; f < 4; f++)
		begin
			for (int k = 0; k < 8; k++)
			begin
				chk_word(rx.words[8 * f + k], exp_word(f, k));
				chk_bit(rx.sofs[8 * f + k], k == 0);
			end
		end
		wr(pfs_pkg::OFS_CTRL, 32'h0, pfs_pkg::RESP_OKAY);
		repeat (3)
			@(posedge aclk);
		chk_bit(pcm_active, 1'b0);
		n = 0;
		repeat (40)
		begin
			@(posedge aclk);
			n += int'(pcm_bit_strobe);
		end
		chk_reg(32'(n), 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
